// [strap_host_slave.v]
// Strap capture at reset release and two-wire host slave port
`timescale 1ns/1ps
`include "strap_host_defines.vh"

module strap_host_slave (
  input wire clk,
  input wire rst,
  input wire [13:0] frame_store_addr_strap_pins,
  output reg frame_store_addr_oe_n,
  output reg [13:0] strap_value,
  output reg strap_valid,
  output reg [6:0] slave_address,
  output reg host_protocol_nibble,
  output reg [7:0] user_bits,
  output reg embedded_cpu_launch_strap,
  output reg [1:0] oversample_clock_select,
  output reg osc_sel_rclk_div2,
  output reg osc_sel_transmit,
  output reg osc_sel_external,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  output reg [8:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  input wire [7:0] reg_rdata
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_LOAD = 6'h08;
  localparam [5:0] ST_TX = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  // Decode of instruction nibble: {write, read, increment}
  function [2:0] op_decode;
    input [3:0] nib;
    begin
      case (nib)
        `OP_WRITE_INC: op_decode = 3'h5;
        `OP_WRITE_FIXED: op_decode = 3'h4;
        `OP_READ_INC: op_decode = 3'h3;
        `OP_READ_FIXED: op_decode = 3'h2;
        default: op_decode = 3'h0;
      endcase
    end
  endfunction

  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;
  reg [5:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [1:0] byte_idx;
  reg read_next;
  reg op_write;
  reg last_inc;
  reg moved_fixed;
  reg op_valid;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire two_wire;
  wire [2:0] op_now;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign two_wire = strap_valid & (strap_value[`STRAP_PROTOCOL_BIT] == `PROTOCOL_TWO_WIRE);
  assign op_now = op_decode(shift[7:4]);

  // Pins released; sampled at first edge after release
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_store_addr_oe_n <= 1'b1;
      strap_valid <= 1'b0;
      strap_value <= `STRAP_RESET_VALUE;
      slave_address <= 7'h00;
      host_protocol_nibble <= 1'b0;
      user_bits <= 8'h00;
      embedded_cpu_launch_strap <= 1'b0;
      oversample_clock_select <= 2'h0;
      osc_sel_rclk_div2 <= 1'b0;
      osc_sel_transmit <= 1'b0;
      osc_sel_external <= 1'b0;
    end else if (!strap_valid) begin
      frame_store_addr_oe_n <= 1'b1;
      strap_valid <= 1'b1;
      strap_value <= frame_store_addr_strap_pins;
      slave_address <= frame_store_addr_strap_pins[`STRAP_ADDR_MSB:`STRAP_ADDR_LSB];
      host_protocol_nibble <= frame_store_addr_strap_pins[`STRAP_PROTOCOL_BIT];
      if (frame_store_addr_strap_pins[`STRAP_PROTOCOL_BIT] != `PROTOCOL_TWO_WIRE) begin
        user_bits <= {frame_store_addr_strap_pins[`STRAP_USER_HI_MSB:`STRAP_USER_HI_LSB],
                      frame_store_addr_strap_pins[`STRAP_USER_LO_MSB:0]};
      end
      embedded_cpu_launch_strap <= frame_store_addr_strap_pins[`STRAP_LAUNCH_BIT];
      oversample_clock_select <= frame_store_addr_strap_pins[`STRAP_CLKSEL_MSB:`STRAP_CLKSEL_LSB];
      osc_sel_rclk_div2 <= frame_store_addr_strap_pins[`STRAP_CLKSEL_MSB:`STRAP_CLKSEL_LSB] == `CLKSEL_RCLK_DIV2;
      osc_sel_transmit <= frame_store_addr_strap_pins[`STRAP_CLKSEL_MSB:`STRAP_CLKSEL_LSB] == `CLKSEL_TRANSMIT;
      osc_sel_external <= frame_store_addr_strap_pins[`STRAP_CLKSEL_LSB];
    end
  end

  // Line synchronisers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Two-wire slave engine
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_idx <= 2'h0;
      read_next <= 1'b0;
      op_write <= 1'b0;
      last_inc <= 1'b0;
      moved_fixed <= 1'b0;
      op_valid <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      reg_addr <= 9'h000;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // Only SDA is ever driven, always low
      sda_out <= 1'b0;
      if (!two_wire) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_seen | stop_seen) begin
        // Restart begins a new transfer, stop ends it
        state <= start_seen ? ST_RX : ST_IDLE;
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        read_next <= 1'b0;
        sda_oe_n <= 1'b1;
        if (moved_fixed) begin
          reg_addr <= reg_addr + 9'h001;
          moved_fixed <= 1'b0;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              sda_oe_n <= 1'b0;
              state <= ST_ACK;
              read_next <= 1'b0;
              if (byte_idx == 2'h0) begin
                if (shift[7:1] == slave_address) begin
                  read_next <= shift[0];
                end else begin
                  sda_oe_n <= 1'b1;
                  state <= ST_IDLE;
                end
              end else if (byte_idx == 2'h1) begin
                op_write <= op_now[2];
                op_valid <= (op_now != 3'h0);
                if (op_now != 3'h0) begin
                  reg_addr[8] <= shift[0];
                  last_inc <= op_now[0];
                end
              end else if (byte_idx == 2'h2) begin
                if (op_valid) begin
                  reg_addr[7:0] <= shift;
                end
              end else if (op_write) begin
                reg_wdata <= shift;
                reg_wr <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (byte_idx != `BYTE_IDX_DATA) begin
                byte_idx <= byte_idx + 2'h1;
              end
              if (byte_idx == `BYTE_IDX_DATA && op_write) begin
                if (last_inc) begin
                  reg_addr <= reg_addr + 9'h001;
                end else begin
                  moved_fixed <= 1'b1;
                end
              end
              if (read_next) begin
                state <= ST_LOAD;
              end else begin
                sda_oe_n <= 1'b1;
                state <= ST_RX;
              end
            end
          end
          ST_LOAD: begin
            if (!reg_rd) begin
              reg_rd <= 1'b1;
            end else begin
              shift <= reg_rdata;
              sda_oe_n <= reg_rdata[7];
              bit_cnt <= 4'h1;
              state <= ST_TX;
            end
          end
          ST_TX: begin
            // Change SDA only after SCL falls
            if (scl_fall) begin
              if (bit_cnt != `BITS_PER_BYTE) begin
                sda_oe_n <= shift[6];
                shift <= {shift[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end else begin
                sda_oe_n <= 1'b1;
                bit_cnt <= 4'h0;
                state <= ST_RACK;
                if (last_inc) begin
                  reg_addr <= reg_addr + 9'h001;
                end else begin
                  moved_fixed <= 1'b1;
                end
              end
            end
          end
          ST_RACK: begin
            if (scl_rise && sda_s) begin
              state <= ST_IDLE;
            end else if (scl_fall) begin
              state <= ST_LOAD;
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // strap_host_slave

// [strap_host_defines.vh]
// Constants for strap capture and the two-wire host slave
`ifndef STRAP_HOST_DEFINES_VH
`define STRAP_HOST_DEFINES_VH

// Strap field positions
`define STRAP_WIDTH 14
`define STRAP_ADDR_MSB 6
`define STRAP_ADDR_LSB 0
`define STRAP_PROTOCOL_BIT 7
`define STRAP_USER_LO_MSB 4
`define STRAP_USER_HI_MSB 10
`define STRAP_USER_HI_LSB 8
`define STRAP_LAUNCH_BIT 11
`define STRAP_CLKSEL_MSB 13
`define STRAP_CLKSEL_LSB 12
`define STRAP_RESET_VALUE 14'h0000

// Host protocol strap level
`define PROTOCOL_TWO_WIRE 1'b0

// Oversampling clock select codes
`define CLKSEL_RCLK_DIV2 2'h0
`define CLKSEL_TRANSMIT 2'h2

// Instruction upper nibbles
`define OP_WRITE_INC 4'h1
`define OP_WRITE_FIXED 4'h2
`define OP_READ_INC 4'h9
`define OP_READ_FIXED 4'hA

// Transfer sizes
`define BITS_PER_BYTE 4'h8
`define REG_ADDR_WIDTH 9
`define BYTE_IDX_DATA 2'h3

`endif

// [strap_host_slave_props.sv]
// Concurrent checks on the strap capture and two-wire slave ports
`timescale 1ns/1ps
module strap_host_slave_props (
  input logic clk, rst, strap_valid, frame_store_addr_oe_n, host_protocol_nibble,
  input logic [13:0] frame_store_addr_strap_pins, strap_value,
  input logic [6:0] slave_address,
  input logic [7:0] user_bits,
  input logic [1:0] oversample_clock_select,
  input logic osc_sel_rclk_div2, osc_sel_transmit, osc_sel_external, sda_out, sda_oe_n, reg_wr, reg_rd,
  input logic scl_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pins_released_a: assert property (frame_store_addr_oe_n)
    else $error("strap pins driven");
  strap_capture_a: assert property ($rose(strap_valid) |-> strap_value == $past(frame_store_addr_strap_pins))
    else $error("strap value not captured at release");
  strap_hold_a: assert property (strap_valid |=> $stable(strap_value))
    else $error("strap value changed");
  addr_proto_a: assert property (strap_valid |-> slave_address == strap_value[6:0]
    && host_protocol_nibble == strap_value[7]) else $error("address or protocol field wrong");
  user_field_a: assert property (strap_valid |-> user_bits ==
    (strap_value[7] ? {strap_value[10:8], strap_value[4:0]} : 8'h00)) else $error("user bits wrong");
  clock_decode_a: assert property (strap_valid |-> oversample_clock_select == strap_value[13:12]
    && osc_sel_rclk_div2 == (oversample_clock_select == 2'h0) && osc_sel_transmit == (oversample_clock_select == 2'h2)
    && osc_sel_external == oversample_clock_select[0]) else $error("clock select decode wrong");
  sda_pull_a: assert property (!sda_out)
    else $error("SDA driven high");
  nibble_quiet_a: assert property (host_protocol_nibble |-> sda_oe_n)
    else $error("SDA pulled in nibble mode");
  sda_stands_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*2])
    else $error("SDA low too short");
  sda_low_phase_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("SDA changed while SCL high");
  write_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  read_spacing_a: assert property (reg_rd |=> !reg_rd [*8])
    else $error("read strobes too close");
  cover property (reg_wr);
  cover property (reg_rd);
  cover property ($fell(sda_oe_n));
endmodule // strap_host_slave_props
bind strap_host_slave strap_host_slave_props u_props (.clk(clk), .rst(rst), .strap_valid(strap_valid),
  .frame_store_addr_oe_n(frame_store_addr_oe_n), .host_protocol_nibble(host_protocol_nibble),
  .frame_store_addr_strap_pins(frame_store_addr_strap_pins), .strap_value(strap_value),
  .slave_address(slave_address), .user_bits(user_bits), .oversample_clock_select(oversample_clock_select),
  .osc_sel_rclk_div2(osc_sel_rclk_div2), .osc_sel_transmit(osc_sel_transmit),
  .osc_sel_external(osc_sel_external), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .scl_in(scl_in));

// [mcu_master_model.sv]
// Two-wire bus master model of the system microcontroller
`timescale 1ns/1ps
module mcu_master_model (
  input wire clk,
  output reg scl,
  output reg sda_drv,
  input wire sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task hp;
    repeat (8) @(posedge clk);
  endtask
  task bitx(input b, output r);
    @(posedge clk) sda_drv <= b;
    hp;
    @(posedge clk) scl <= 1'b1;
    hp;
    r = sda;
    @(posedge clk) scl <= 1'b0;
  endtask
  task start;
    @(posedge clk) sda_drv <= 1'b1;
    hp;
    @(posedge clk) scl <= 1'b1;
    hp;
    @(posedge clk) sda_drv <= 1'b0;
    hp;
    @(posedge clk) scl <= 1'b0;
    hp;
  endtask
  task stop;
    @(posedge clk) sda_drv <= 1'b0;
    hp;
    @(posedge clk) scl <= 1'b1;
    hp;
    @(posedge clk) sda_drv <= 1'b1;
    hp;
  endtask
  task wbyte(input [7:0] d, output ack);
    reg r;
    integer i;
    for (i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task rbyte(input more, output [7:0] d);
    reg r;
    integer i;
    for (i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~more, r);
  endtask
endmodule // mcu_master_model

// [strap_capture_two_wire_host_slave_test.sv]
// Self-checking bench for strap capture and the two-wire host slave
`timescale 1ns/1ps
`include "strap_host_defines.vh"
module strap_capture_two_wire_host_slave_test;
  reg clk, rst, ack;
  reg [13:0] pins, p;
  reg [7:0] reg_rdata;
  integer fail_count, cmp_count, k, rd_cnt;
  reg [16:0] wlog[$], exq[$];
  wire oe_n, valid, nib, launch, rclk2, tsel, esel, sda_o, sda_oe_n, scl, sda_m, reg_wr, reg_rd;
  wire [13:0] sv;
  wire [6:0] sa;
  wire [7:0] ub, wdata;
  wire [1:0] cs;
  wire [8:0] ra;
  wire sda = sda_m & (sda_oe_n | sda_o);
  strap_host_slave DUT (.clk(clk), .rst(rst), .frame_store_addr_strap_pins(pins), .frame_store_addr_oe_n(oe_n),
    .strap_value(sv), .strap_valid(valid), .slave_address(sa), .host_protocol_nibble(nib), .user_bits(ub),
    .embedded_cpu_launch_strap(launch), .oversample_clock_select(cs), .osc_sel_rclk_div2(rclk2),
    .osc_sel_transmit(tsel), .osc_sel_external(esel), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_n(sda_oe_n), .reg_addr(ra), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mcu_master_model m (.clk(clk), .scl(scl), .sda_drv(sda_m), .sda(sda));
  function [7:0] rd_f(input [8:0] a);
    rd_f = a[7:0] ^ 8'h5C ^ {a[8], 7'h00};
  endfunction
  function [15:0] exp_fields(input [13:0] q);
    exp_fields = {q[6:0], q[7], q[7] ? {q[10:8], q[4:0]} : 8'h00};
  endfunction
  function [5:0] exp_clk(input [13:0] q);
    exp_clk = {q[11], q[13:12], q[13:12] == 2'h0, q[13:12] == 2'h2, q[12]};
  endfunction
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    reg_rdata <= rd_f(ra);
    if (reg_rd) rd_cnt++;
    if (reg_wr) wlog.push_back({ra, wdata});
  end
  task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task do_reset(input [13:0] q);
    @(posedge clk);
    rst <= 1'b1;
    pins <= q;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    pins <= $urandom;
    @(posedge clk);
    #1;
    chk("strap_value", q, sv);
    chk("fields", exp_fields(q), {sa, nib, ub});
    chk("clock", exp_clk(q), {launch, cs, rclk2, tsel, esel});
  endtask
  task wr_xfer(input [3:0] op, input [8:0] a, input integer n);
    reg [7:0] d;
    integer i;
    m.start;
    m.wbyte({sv[6:0], 1'b0}, ack);
    m.wbyte({op, 3'b111, a[8]}, ack);
    m.wbyte(a[7:0], ack);
    chk("instr ack", 1, ack);
    for (i = 0; i < n; i++) begin
      d = $urandom;
      m.wbyte(d, ack);
      chk("data ack", 1, ack);
      if (op == `OP_WRITE_INC || op == `OP_WRITE_FIXED)
        exq.push_back({op == `OP_WRITE_INC ? a + i[8:0] : a, d});
    end
    m.stop;
  endtask
  task rd_xfer(input [3:0] op, input [8:0] a, input integer n, input dir);
    reg [7:0] d;
    integer i;
    integer c0;
    c0 = rd_cnt;
    if (!dir) begin
      m.start;
      m.wbyte({sv[6:0], 1'b0}, ack);
      m.wbyte({op, 3'b111, a[8]}, ack);
      m.wbyte(a[7:0], ack);
    end
    m.start;
    m.wbyte({sv[6:0], 1'b1}, ack);
    for (i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk("read", rd_f(op == `OP_READ_INC ? a + i[8:0] : a), d);
    end
    m.stop;
    chk("load count", n, rd_cnt - c0);
  endtask
  initial begin
    rst = 1'b1;
    pins = 14'h0000;
    rd_cnt = 0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'hA7934DC4));
    for (k = 0; k < 5; k++) begin
      p = $urandom;
      p[13:12] = k[1:0];
      p[7] = k[0] & (k < 4);
      p[11] = 1'b0;
      if (p[7]) p[6:5] = 2'h0;
      do_reset(p);
      m.start;
      m.wbyte({p[6:0], 1'b0}, ack);
      m.stop;
      chk("nibble ack", !p[7], ack);
    end
    m.start;
    m.wbyte({~sv[6:0], 1'b0}, ack);
    m.stop;
    chk("foreign ack", 0, ack);
    wr_xfer(`OP_WRITE_INC, 9'h0FE, 3);
    wr_xfer(`OP_WRITE_FIXED, 9'h1A0, 3);
    for (k = 0; k < 16; k++)
      if (k != 1 && k != 2 && k != 9 && k != 10) wr_xfer(k[3:0], 9'h030, 1);
    chk("write count", exq.size(), wlog.size());
    while (exq.size() > 0 && wlog.size() > 0)
      chk("write", exq.pop_front(), wlog.pop_front());
    rd_xfer(`OP_READ_FIXED, 9'h1A1, 1, 1);
    rd_xfer(`OP_READ_FIXED, 9'h055, 3, 0);
    rd_xfer(`OP_READ_FIXED, 9'h056, 2, 1);
    rd_xfer(`OP_READ_INC, 9'h0FF, 3, 0);
    rd_xfer(`OP_READ_INC, 9'h102, 2, 1);
    give_verdict;
  end
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule // strap_capture_two_wire_host_slave_test
